// ### design/mdu_top.sv
`timescale 1ns/1ps
`include "mdu_consts.svh"
module mdu_top
  import mdu_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire mdu_sfr_t sfr_i,
  output logic [7:0] rdata_o,
  output logic busy_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] opb_r [0:5];
  logic [7:0] ctrl_r;
  logic [7:0] rdata_r;
  logic busy_out_r;
  mdu_seq_t seq_r;
  mdu_seq_t seq_nxt;
  mdu_op_t launch;
  logic eng_busy;
  logic eng_done;
  logic [47:0] eng_res;
  logic eng_ovf;
  logic [4:0] eng_cnt;
  mdu_op_t last_op_r;
  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire wr_en = sfr_i.wr;
  wire w0 = wr_en && sfr_i.addr == `MDU_ADDR_OPB0;
  wire w1 = wr_en && sfr_i.addr == `MDU_ADDR_OPB1;
  wire w2 = wr_en && sfr_i.addr == `MDU_ADDR_OPB2;
  wire w3 = wr_en && sfr_i.addr == `MDU_ADDR_OPB3;
  wire w4 = wr_en && sfr_i.addr == `MDU_ADDR_OPB4;
  wire w5 = wr_en && sfr_i.addr == `MDU_ADDR_OPB5;
  wire wc = wr_en && sfr_i.addr == `MDU_ADDR_CTRL;
  wire any_op_wr = w0 | w1 | w2 | w3 | w4 | w5 | wc;
  wire [2:0] rd_idx = 3'(sfr_i.addr - `MDU_ADDR_OPB0);
  wire rd_opb = sfr_i.rd && sfr_i.addr >= `MDU_ADDR_OPB0 && sfr_i.addr <= `MDU_ADDR_OPB5;
  wire rd_ctl = sfr_i.rd && sfr_i.addr == `MDU_ADDR_CTRL;
  ////////////////////////////////////////////////////////////////////////////
  // Write-order detection: operation chosen by sequence, shift versus normalize by the count field
  always_comb begin
    seq_nxt = seq_r;
    launch = OP_NONE;
    if (any_op_wr) begin
      seq_nxt = w0 ? SQ_W0 : SQ_IDLE;
      case (seq_r)
        SQ_W0: begin
          if (w1) seq_nxt = SQ_D1;
          if (w4) seq_nxt = SQ_M4;
        end
        SQ_D1: begin
          if (w2) seq_nxt = SQ_D2;
          if (w4) seq_nxt = SQ_H4;
        end
        SQ_D2: if (w3) seq_nxt = SQ_D3;
        SQ_D3: begin
          if (w4) seq_nxt = SQ_D4;
          if (wc) begin
            launch = (sfr_i.wdata[`MDU_CNT_HI:0] == 5'd0) ? OP_NORM : OP_SHIFT;
            seq_nxt = SQ_IDLE;
          end
        end
        SQ_D4: if (w5) launch = OP_DIV32;
        SQ_H4: if (w5) launch = OP_DIV16;
        SQ_M4: if (w1) seq_nxt = SQ_M1;
        SQ_M1: if (w5) launch = OP_MUL;
        default: ;
      endcase
      if (launch != OP_NONE) seq_nxt = SQ_IDLE;
    end
  end
  // Engine runs alongside the CPU; only a register access touches it
  mdu_engine u_engine (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(launch != OP_NONE),
    .op_i(launch),
    .opnd_i({(w5 ? sfr_i.wdata : opb_r[5]), opb_r[4], opb_r[3], opb_r[2], opb_r[1], opb_r[0]}),
    .dir_right_i(sfr_i.wdata[`MDU_BIT_DIR]),
    .cnt_i(sfr_i.wdata[`MDU_CNT_HI:0]),
    .busy_o(eng_busy),
    .done_o(eng_done),
    .res_o(eng_res),
    .ovf_o(eng_ovf),
    .cnt_o(eng_cnt)
  );
  // Restarting while busy is the only error source; flag stays until software writes it
  wire restart_err = (launch != OP_NONE) && eng_busy;
  wire rd_last = rd_opb && ((last_op_r == OP_DIV32 && rd_idx == 3'd5) ||
                 (last_op_r == OP_DIV16 && rd_idx == 3'd5) ||
                 (last_op_r != OP_DIV32 && last_op_r != OP_DIV16 && rd_idx == 3'd3));
  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_opb
      wire wsel = wr_en && sfr_i.addr == 8'(`MDU_ADDR_OPB0 + g);
      always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) opb_r[g] <= `MDU_RST_BYTE;
        else if (eng_done && !(last_op_r == OP_DIV16 && (g == 2 || g == 3)) &&
                 !(last_op_r != OP_DIV32 && last_op_r != OP_DIV16 && g > 3))
          opb_r[g] <= eng_res[g*8 +: 8];
        else if (wsel) opb_r[g] <= sfr_i.wdata;
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ctrl_r <= `MDU_RST_BYTE;
      seq_r <= SQ_IDLE;
      last_op_r <= OP_NONE;
    end else begin
      seq_r <= (rd_last && !any_op_wr) ? SQ_IDLE : seq_nxt;
      if (launch != OP_NONE) last_op_r <= launch;
      if (wc) ctrl_r <= sfr_i.wdata;
      if (eng_done) begin
        ctrl_r[`MDU_BIT_OVF] <= eng_ovf;
        if (last_op_r == OP_NORM) ctrl_r[`MDU_CNT_HI:0] <= eng_cnt;
      end
      if (restart_err) ctrl_r[`MDU_BIT_ERR] <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  wire [7:0] rd_mux = rd_opb ? opb_r[rd_idx] : (rd_ctl ? ctrl_r : 8'h00);
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= 8'h00;
      busy_out_r <= 1'b0;
    end else begin
      rdata_r <= rd_mux;
      busy_out_r <= eng_busy;
    end
  end
  assign rdata_o = rdata_r;
  assign busy_o = busy_out_r;
endmodule // mdu_top

// ### design/mdu_consts.svh
`ifndef MDU_CONSTS_SVH
`define MDU_CONSTS_SVH
`define MDU_ADDR_OPB0 8'hE9
`define MDU_ADDR_OPB1 8'hEA
`define MDU_ADDR_OPB2 8'hEB
`define MDU_ADDR_OPB3 8'hEC
`define MDU_ADDR_OPB4 8'hED
`define MDU_ADDR_OPB5 8'hEE
`define MDU_ADDR_CTRL 8'hEF
`define MDU_RST_BYTE 8'h00
`define MDU_BIT_ERR 7
`define MDU_BIT_OVF 6
`define MDU_BIT_DIR 5
`define MDU_CNT_HI 4
`define MDU_CYC_DIV32 5'd17
`define MDU_CYC_DIV16 5'd9
`define MDU_CYC_MUL 5'd11
`define MDU_CYC_SHIFT_BASE 5'd3
`define MDU_CYC_NORM_BASE 5'd4
`define MDU_STEP_DIV32 6'd32
`define MDU_STEP_DIV16 6'd16
`endif

// ### design/mdu_pkg.sv
package mdu_pkg;
  typedef enum logic [3:0] {
    SQ_IDLE = 4'b0000,
    SQ_W0 = 4'b0001,
    SQ_D1 = 4'b0010,
    SQ_D2 = 4'b0011,
    SQ_D3 = 4'b0100,
    SQ_D4 = 4'b0101,
    SQ_H4 = 4'b0110,
    SQ_M4 = 4'b0111,
    SQ_M1 = 4'b1000
  } mdu_seq_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_DIV32 = 3'b001,
    OP_DIV16 = 3'b010,
    OP_MUL = 3'b011,
    OP_SHIFT = 3'b100,
    OP_NORM = 3'b101
  } mdu_op_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mdu_sfr_t;
endpackage

// ### design/mdu_engine.sv
`timescale 1ns/1ps
`include "mdu_consts.svh"
module mdu_engine
  import mdu_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire mdu_op_t op_i,
  input wire logic [47:0] opnd_i,
  input wire logic dir_right_i,
  input wire logic [4:0] cnt_i,
  output logic busy_o,
  output logic done_o,
  output logic [47:0] res_o,
  output logic ovf_o,
  output logic [4:0] cnt_o
);
  // Restoring divider, two quotient bits per cycle; cycle totals padded to the fixed figures
  logic [31:0] acc_r;
  logic [31:0] quo_r;
  logic [15:0] rem_r;
  logic [15:0] dsr_r;
  logic [4:0] left_r;
  logic [4:0] cnt_r;
  mdu_op_t op_r;
  logic busy_r;
  logic done_r;
  logic ovf_r;
  logic [47:0] res_r;
  wire [16:0] trial_1 = {rem_r, quo_r[31]} - {1'b0, dsr_r};
  wire ge_1 = !trial_1[16];
  wire [15:0] rem_1 = ge_1 ? trial_1[15:0] : {rem_r[14:0], quo_r[31]};
  wire [31:0] quo_1 = {quo_r[30:0], ge_1};
  wire [16:0] trial_2 = {rem_1, quo_1[31]} - {1'b0, dsr_r};
  wire ge_2 = !trial_2[16];
  wire [15:0] rem_2 = ge_2 ? trial_2[15:0] : {rem_1[14:0], quo_1[31]};
  wire [31:0] quo_2 = {quo_1[30:0], ge_2};
  wire [31:0] product = opnd_i[15:0] * opnd_i[47:32];
  wire [4:0] lead;
  wire [31:0] val_in = opnd_i[31:0];
  logic [4:0] lz;
  always_comb begin
    lz = 5'd0;
    for (int i = 0; i < 32; i++) begin
      if (val_in[i]) begin
        lz = 5'(31 - i);
      end
    end
  end
  assign lead = lz;
  wire [4:0] norm_cyc = (lead == 5'd0) ? `MDU_CYC_NORM_BASE : 5'(`MDU_CYC_NORM_BASE + ((lead - 5'd1) >> 1));
  // Counts one and two take the base figure, each further pair of bits one more cycle
  wire [4:0] shift_cyc = 5'(`MDU_CYC_SHIFT_BASE + ((cnt_i - 5'd1) >> 1));
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ovf_r <= 1'b0;
      left_r <= 5'd0;
      op_r <= OP_NONE;
      acc_r <= 32'h0000_0000;
      quo_r <= 32'h0000_0000;
      rem_r <= 16'h0000;
      dsr_r <= 16'h0000;
      cnt_r <= 5'd0;
      res_r <= 48'h0000_0000_0000;
    end else begin
      done_r <= 1'b0;
      if (start_i) begin
        busy_r <= 1'b1;
        op_r <= op_i;
        ovf_r <= 1'b0;
        rem_r <= 16'h0000;
        dsr_r <= opnd_i[47:32];
        cnt_r <= 5'd0;
        case (op_i)
          OP_DIV32: begin
            quo_r <= opnd_i[31:0];
            left_r <= `MDU_CYC_DIV32;
            ovf_r <= (opnd_i[47:32] == 16'h0000);
          end
          OP_DIV16: begin
            quo_r <= {opnd_i[15:0], 16'h0000};
            left_r <= `MDU_CYC_DIV16;
            ovf_r <= (opnd_i[47:32] == 16'h0000);
          end
          OP_MUL: begin
            acc_r <= product;
            left_r <= `MDU_CYC_MUL;
          end
          OP_SHIFT: begin
            acc_r <= dir_right_i ? (val_in >> cnt_i) : (val_in << cnt_i);
            cnt_r <= cnt_i;
            left_r <= shift_cyc;
          end
          default: begin
            acc_r <= val_in << lead;
            cnt_r <= lead;
            left_r <= norm_cyc;
          end
        endcase
      end else if (busy_r) begin
        if ((op_r == OP_DIV32 || op_r == OP_DIV16) && left_r > 5'd1) begin
          quo_r <= quo_2;
          rem_r <= rem_2;
        end
        left_r <= left_r - 5'd1;
        if (left_r == 5'd1) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          case (op_r)
            OP_DIV32: res_r <= {rem_r, quo_r};
            OP_DIV16: res_r <= {rem_r, 16'h0000, quo_r[15:0]};
            default: res_r <= {16'h0000, acc_r};
          endcase
        end
      end
    end
  end
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign res_o = res_r;
  assign ovf_o = ovf_r;
  assign cnt_o = cnt_r;
endmodule // mdu_engine

// ### sim/mdu_top_monitor.sv
`timescale 1ns/1ps
module mdu_top_monitor
  import mdu_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire mdu_sfr_t sfr_i,
  input wire logic [7:0] rdata_o,
  input wire logic busy_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////
  // Address decode of the incoming strobe, shared by several checks
  wire in_map = sfr_i.addr >= 8'hE9 && sfr_i.addr <= 8'hEF;
  wire w_b0 = sfr_i.wr && sfr_i.addr == 8'hE9;
  wire w_b1 = sfr_i.wr && sfr_i.addr == 8'hEA;
  wire w_b4 = sfr_i.wr && sfr_i.addr == 8'hED;
  wire w_b5 = sfr_i.wr && sfr_i.addr == 8'hEE;
  ////////////////////////////////////////////////////////////////
  chk_reset_quiet: assert property ($rose(rst_n_i) |-> (rdata_o == 8'h00 && !busy_o)[*3])
    else $error("outputs not quiet after reset");
  chk_idle_read_zero: assert property (!$past(sfr_i.rd) |-> rdata_o == 8'h00)
    else $error("read data without a read strobe");
  chk_unmapped_zero: assert property (sfr_i.rd && !in_map |=> rdata_o == 8'h00)
    else $error("unmapped read returned data");
  chk_busy_cause: assert property ($rose(busy_o) |-> $past(sfr_i.wr) || $past(sfr_i.wr, 2) || $past(sfr_i.wr, 3))
    else $error("busy rose without a launching write");
  chk_busy_bound: assert property ($rose(busy_o) |-> ##[1:19] !busy_o)
    else $error("operation ran too long");
  chk_busy_min: assert property ($rose(busy_o) |-> busy_o[*2])
    else $error("operation ended too early");
  chk_mul_launch: assert property (w_b0 ##1 w_b4 ##1 w_b1 ##1 w_b5 |-> ##[1:3] busy_o)
    else $error("multiply order did not launch");
  chk_div_launch: assert property (w_b0 ##1 w_b1 ##1 w_b4 ##1 w_b5 |-> ##[1:3] busy_o)
    else $error("short divide order did not launch");
endmodule // mdu_top_monitor

bind mdu_top mdu_top_monitor u_mon (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sfr_i(sfr_i),
  .rdata_o(rdata_o), .busy_o(busy_o));

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mdu_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  mdu_sfr_t sfr = '0;
  wire [7:0] rdata;
  wire busy;
  logic [31:0] seed = 32'h0000_a60e;
  logic [31:0] x;
  logic [31:0] y;
  logic [15:0] nt;
  logic [15:0] exp_q[$];
  logic rd_seen = 1'b0;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  mdu_top dut (.ref_clk_i(clk), .rst_n_i(rst_n), .sfr_i(sfr), .rdata_o(rdata), .busy_o(busy));
  initial forever #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic end_sim();
    if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Strobes stay up until the next call, so accesses can run back to back
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr <= '{w, !w, a, d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    exp_q.push_back({m, e & m});
    acc(1'b0, a, 8'h00);
  endtask
  task automatic wbytes(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) wr(8'(8'hE9 + i), v[8*i+:8]);
  endtask
  task automatic rd4(input logic [31:0] v);
    for (int i = 0; i < 4; i++) rd(8'(8'hE9 + i), v[8*i+:8]);
  endtask
  // Busy lags the launch by two cycles; the count bound only guards a hang
  task automatic run(input int lo, input int hi);
    int n;
    n = 0;
    @(negedge clk);
    sfr <= '0;
    @(negedge clk);
    while (busy === 1'b1 && n < 40) begin
      n++;
      @(negedge clk);
    end
    if (lo > 0) begin
      comparisons++;
      if (n < lo || n > hi) begin
        n_mismatch++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, lo, n);
      end
    end
  endtask
  task automatic mulw(input logic [15:0] a, input logic [15:0] b);
    wr(8'hE9, a[7:0]);
    wr(8'hED, b[7:0]);
    wr(8'hEA, a[15:8]);
    wr(8'hEE, b[15:8]);
  endtask
  task automatic div(input logic [31:0] n, input logic [15:0] d, input logic w);
    logic [31:0] q;
    logic [15:0] r;
    q = n / d;
    r = 16'(n % d);
    wbytes(n, w ? 4 : 2);
    wr(8'hED, d[7:0]);
    wr(8'hEE, d[15:8]);
    run(w ? 17 : 9, w ? 17 : 9);
    rd(8'hE9, q[7:0]);
    rd(8'hEA, q[15:8]);
    if (w) begin
      rd(8'hEB, q[23:16]);
      rd(8'hEC, q[31:24]);
    end
    rd(8'hED, r[7:0]);
    rd(8'hEE, r[15:8]);
  endtask
  task automatic sh(input logic [31:0] v, input logic d, input logic [4:0] c);
    wbytes(v, 4);
    wr(8'hEF, {2'b00, d, c});
    run(c == 5'd31 ? 18 : 3, c == 5'd1 ? 3 : 18);
    rd4(d ? v >> c : v << c);
  endtask
  task automatic nrm(input logic [31:0] v);
    logic [31:0] e;
    logic [4:0] lz;
    e = v;
    lz = 5'd0;
    while (!e[31]) begin
      e = e << 1;
      lz++;
    end
    wbytes(v, 4);
    wr(8'hEF, 8'h00);
    run(lz == 5'd31 ? 19 : 4, lz == 5'd1 ? 4 : 19);
    rd4(e);
    rd(8'hEF, {3'b000, lz}, 8'h1F);
  endtask
  ////////////////////////////////////////////////////////////////
  // Results are checked in order of issue, one cycle after each read
  always @(posedge clk) rd_seen <= sfr.rd;
  // A read with no note behind it can never match: mask zero, expected one
  always @(negedge clk) begin
    cyc++;
    if (rd_seen) begin
      nt = 16'h0001;
      if (exp_q.size() > 0) nt = exp_q.pop_front();
      comparisons++;
      if ((rdata & nt[15:8]) !== nt[7:0]) begin
        n_mismatch++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, nt[7:0], rdata & nt[15:8]);
      end
    end
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(8'hE8 + i), 8'h00);
    wr(8'hEF, 8'h25);
    rd(8'hEF, 8'h25);
    for (int i = 0; i < 4; i++) begin
      x = rnd();
      y = rnd();
      mulw(x[15:0], y[15:0]);
      run(11, 11);
      rd4(x[15:0] * y[15:0]);
      div(x, y[15:0] | 16'h0001, 1'b1);
      div({16'h0000, x[15:0]}, y[31:16] | 16'h0001, 1'b0);
      sh(x, y[5], (i == 0) ? 5'd1 : (i == 1) ? 5'd31 : y[4:0] | 5'd1);
      nrm((x | 32'h8000_0000) >> ((i == 1) ? 31 : y[12:8] % 31 + 1));
    end
    wbytes(x, 2);
    wr(8'hED, 8'h00);
    wr(8'hEE, 8'h00);
    run(9, 9);
    rd(8'hEF, 8'h40, 8'h40);
    // Second launch lands while the first multiply is still running
    mulw(x[15:0], y[15:0]);
    mulw(y[15:0], x[15:0]);
    run(0, 0);
    rd(8'hEF, 8'h80, 8'h80);
    run(0, 0);
    end_sim();
  end
endmodule // tb_top
